// file: logic/ladder_pkg.sv
// constants shared by the ladder reference control block
package ladder_pkg;

   // apb register map, byte addresses
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;

   // control register field positions
   localparam int POWER_BIT = 7;
   localparam int PIN_OE_BIT = 6;
   localparam int RANGE_BIT = 5;
   localparam int SOURCE_BIT = 4;
   localparam int TAP_MSB = 3;
   localparam int TAP_LSB = 0;
   localparam int CTRL_WIDTH = 8;
   localparam int TAP_WIDTH = 4;

   // reset value of the control register
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // status register field positions
   localparam int ST_ROUTED_BIT = 8;
   localparam int ST_LEVEL_LSB = 0;
   localparam int ST_LEVEL_MSB = 6;

   // level code is in units of one ninety-sixth of the supply span
   localparam int LEVEL_WIDTH = 7;
   localparam int LEVEL_DEN = 96;
   localparam logic [6:0] LOW_STEP = 7'h04;   // 1/24 = 4/96
   localparam logic [6:0] HIGH_BASE = 7'h18;  // 1/4 = 24/96
   localparam logic [6:0] HIGH_STEP = 7'h03;  // 1/32 = 3/96

   // range encodings of the range field
   localparam logic RANGE_LOW = 1'b1;
   localparam logic RANGE_HIGH = 1'b0;

   // source encodings of the source field
   localparam logic SOURCE_EXT_PINS = 1'b1;
   localparam logic SOURCE_ANALOG_RAILS = 1'b0;

   // apb read data width
   localparam int DATA_WIDTH = 32;

endpackage : ladder_pkg

// file: logic/ladder_level_calc.sv
// registered level code of the selected ladder tap, in 1/96 of the span
`timescale 1ns/1ps

module ladder_level_calc #(
   parameter int TAP_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // settings
   input wire logic range_low,
   input wire logic [TAP_W-1:0] tap,
   // level
   output logic [6:0] level
);

   typedef struct packed {
      logic [6:0] level;
   } calc_s;

   calc_s st_q;
   calc_s st_d;
   logic [6:0] tap_ext;

   // low range: tap/24; high range: 1/4 + tap/32
   always_comb begin
      tap_ext = 7'(tap);
      st_d = st_q;
      if (range_low == ladder_pkg::RANGE_LOW) begin
         st_d.level = 7'(tap_ext * ladder_pkg::LOW_STEP); // [RULE_03] [RULE_05]
      end else begin
         st_d.level = 7'(ladder_pkg::HIGH_BASE + tap_ext * ladder_pkg::HIGH_STEP); // [RULE_05]
      end
   end

   // registered so the level output comes from a flop
   always_ff @(posedge clk) begin
      if (!resetn) begin
         // the cleared register means high range at tap zero, so start at that
         // code; a zero here would show a false step just after release
         st_q.level <= ladder_pkg::HIGH_BASE; // [RULE_06]
      end else begin
         st_q <= st_d;
      end
   end

   assign level = st_q.level;

endmodule : ladder_level_calc

// file: logic/ladder_pad_route.sv
// switch that puts the ladder level on the shared reference pin
`timescale 1ns/1ps

module ladder_pad_route (
   // settings
   input wire logic pin_oe,
   input wire logic dir_input,
   // pad controls
   output logic route_on,
   output logic digital_in_off
);

   // route only when enabled and the pin is set as input; the digital
   // driver would otherwise fight the weak ladder output
   assign route_on = pin_oe & dir_input; // [RULE_02]
   // the digital input buffer draws current on an analog level
   assign digital_in_off = pin_oe & dir_input;

endmodule : ladder_pad_route

// file: logic/ladder_reference_control.sv
// apb control register bank of the 16-tap resistor ladder reference
//
// Contract
// (RULE_01) power bit 7 powers the ladder
// (RULE_02) pin output only if bit 6 and input
// (RULE_03) bit 5 one low range, zero high
// (RULE_04) bit 4 selects external pins or rails
// (RULE_05) low four bits give tap 0 to 15
// (RULE_06) any reset clears the whole register
// (RULE_07) wake from sleep keeps every bit
// (RULE_08) independent of the comparator mode
// (RULE_09) software disables ladder before sleep
// (RULE_10) all eight bits read back as written
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module ladder_reference_control (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // port f direction bit of the shared pin, one means input
   input wire logic port_f_direction,
   // analog ladder controls
   output logic ladder_power_enable,
   output logic ladder_range_select,
   output logic ladder_source_select,
   output logic [3:0] ladder_tap_index,
   output logic [6:0] ladder_output_level,
   // pad controls of the shared reference pin
   output logic ladder_pin_output_enable,
   output logic shared_reference_pin_route,
   output logic shared_reference_pin_din_off
);

   typedef struct packed {
      logic [7:0] ctrl;
      logic [31:0] rdata;
   } bank_s;

   bank_s st_q;
   bank_s st_d;

   logic setup_phase;
   logic access_phase;
   logic hit_ctrl;
   logic hit_status;
   logic mapped;
   logic wr_ctrl;
   logic [6:0] level;
   logic route_on;
   logic din_off;
   logic [31:0] status_word;

   // apb decode; the slave never inserts wait states
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign hit_ctrl = (paddr == ladder_pkg::CTRL_OFFSET);
   assign hit_status = (paddr == ladder_pkg::STATUS_OFFSET);
   assign mapped = hit_ctrl | hit_status;
   assign pready = 1'b1;
   // unmapped addresses and writes to the read-only status word fail
   assign pslverr = access_phase & (~mapped | (hit_status & pwrite));
   // byte lane 0 carries the whole control register
   assign wr_ctrl = access_phase & pwrite & hit_ctrl & pstrb[0];

   // status shows what the analog side really sees
   always_comb begin
      status_word = '0;
      status_word[ladder_pkg::ST_LEVEL_MSB:ladder_pkg::ST_LEVEL_LSB] = level;
      status_word[ladder_pkg::ST_ROUTED_BIT] = route_on;
   end

   // next state: register write and read data capture
   always_comb begin
      st_d = st_q;
      if (wr_ctrl) begin
         st_d.ctrl = pwdata[7:0]; // [RULE_10]
      end
      // no sleep or wake term touches ctrl, so it survives a wake
      // from sleep unchanged [RULE_07]
      if (setup_phase && !pwrite) begin
         // read data is taken a cycle early so prdata comes from a flop
         if (hit_ctrl) begin
            st_d.rdata = {24'h000000, st_q.ctrl}; // [RULE_10]
         end else if (hit_status) begin
            st_d.rdata = status_word;
         end else begin
            st_d.rdata = 32'h00000000;
         end
      end
   end

   // one register stage for all state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_q.ctrl <= ladder_pkg::CTRL_RESET; // [RULE_06]
         st_q.rdata <= 32'h00000000;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.rdata;

   // field outputs straight from the control flops; the comparator mode
   // is not an input here, so these act in every comparator mode [RULE_08]
   assign ladder_power_enable = st_q.ctrl[ladder_pkg::POWER_BIT]; // [RULE_01]
   assign ladder_pin_output_enable = st_q.ctrl[ladder_pkg::PIN_OE_BIT]; // [RULE_02]
   assign ladder_range_select = st_q.ctrl[ladder_pkg::RANGE_BIT]; // [RULE_03]
   assign ladder_source_select = st_q.ctrl[ladder_pkg::SOURCE_BIT]; // [RULE_04]
   assign ladder_tap_index = st_q.ctrl[ladder_pkg::TAP_MSB:ladder_pkg::TAP_LSB]; // [RULE_05]
   // level code follows the register one cycle later
   assign ladder_output_level = level;
   assign shared_reference_pin_route = route_on;
   assign shared_reference_pin_din_off = din_off;

   // tap to level code
   ladder_level_calc #(
      .TAP_W(ladder_pkg::TAP_WIDTH)
   ) u_level (
      .clk(clk),
      .resetn(resetn),
      .range_low(st_q.ctrl[ladder_pkg::RANGE_BIT]),
      .tap(st_q.ctrl[ladder_pkg::TAP_MSB:ladder_pkg::TAP_LSB]),
      .level(level)
   );

   // pin routing switch
   ladder_pad_route u_pad (
      .pin_oe(st_q.ctrl[ladder_pkg::PIN_OE_BIT]),
      .dir_input(port_f_direction),
      .route_on(route_on),
      .digital_in_off(din_off)
   );

   // checks on the block's own outputs
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // reset loads all zeros, whatever was there before
   reset_clear_a: assert property ( // [RULE_06]
      disable iff (1'b0) !resetn |=> (st_q.ctrl == 8'h00) && !ladder_power_enable
         && !ladder_pin_output_enable && !shared_reference_pin_route)
      else $error("control register not cleared by reset");

   // a write lands in the register at the access edge
   ctrl_write_a: assert property ( // [RULE_10]
      wr_ctrl |=> st_q.ctrl == $past(pwdata[7:0]))
      else $error("control write not stored");

   // without a write the register holds, sleep or not
   ctrl_hold_a: assert property ( // [RULE_07]
      !wr_ctrl |=> $stable(st_q.ctrl))
      else $error("control register changed without a write");

   // a read of the control word returns the last value written
   ctrl_read_a: assert property ( // [RULE_10]
      (setup_phase && !pwrite && hit_ctrl) ##1 (access_phase && hit_ctrl)
         |-> prdata == {24'h000000, st_q.ctrl})
      else $error("control read back wrong");

   // power output follows the written bit one cycle after the write
   power_follow_a: assert property ( // [RULE_01]
      wr_ctrl |=> ladder_power_enable == $past(pwdata[7]))
      else $error("ladder power does not follow its bit");

   // pin is routed exactly when enable set and direction is input
   pin_route_a: assert property ( // [RULE_02]
      shared_reference_pin_route == (ladder_pin_output_enable && port_f_direction))
      else $error("pin routing wrong");

   // source select follows bit 4 of the last write
   source_follow_a: assert property ( // [RULE_04]
      wr_ctrl |=> ladder_source_select == $past(pwdata[4]))
      else $error("source select does not follow its bit");

   // low range level is tap times four ninety-sixths, two cycles on
   level_low_a: assert property ( // [RULE_03]
      wr_ctrl && pwdata[5] |=> ##1 ladder_output_level == 7'($past(pwdata[3:0], 2) * 4))
      else $error("low range level wrong");

   // high range level is a quarter plus tap times three ninety-sixths
   level_high_a: assert property ( // [RULE_05]
      wr_ctrl && !pwdata[5] |=> ##1
         ladder_output_level == 7'(24 + $past(pwdata[3:0], 2) * 3))
      else $error("high range level wrong");

   // level does not move while the register holds
   comparator_free_a: assert property ( // [RULE_08]
      !wr_ctrl [*3] |-> $stable(ladder_output_level))
      else $error("level changed with no register write");

   // unmapped access is refused with an error
   unmapped_err_a: assert property (
      access_phase && !mapped |-> pslverr && pready)
      else $error("unmapped access not refused");

   // range output follows bit 5 of the last write
   range_follow_a: assert property ( // [RULE_03]
      wr_ctrl |=> ladder_range_select == $past(pwdata[5]))
      else $error("range select does not follow its bit");

   // tap output follows the low four bits of the last write
   tap_follow_a: assert property ( // [RULE_05]
      wr_ctrl |=> ladder_tap_index == $past(pwdata[3:0]))
      else $error("tap index does not follow its bits");

   // pin output enable follows bit 6 of the last write
   pin_oe_follow_a: assert property ( // [RULE_02]
      wr_ctrl |=> ladder_pin_output_enable == $past(pwdata[6]))
      else $error("pin output enable does not follow its bit");

   // digital input buffer is off exactly while the level is on the pin
   din_off_a: assert property ( // [RULE_02]
      shared_reference_pin_din_off == shared_reference_pin_route)
      else $error("pin input buffer state wrong");

   // power, tap, range and source outputs do not move without a write, so a wake keeps them
   fields_hold_a: assert property ( // [RULE_07]
      !wr_ctrl |=> $stable(ladder_power_enable) && $stable(ladder_tap_index)
         && $stable(ladder_range_select) && $stable(ladder_source_select))
      else $error("field output changed without a write");

   // a write with lane 0 off leaves the register alone
   masked_write_a: assert property ( // [RULE_10]
      access_phase && pwrite && hit_ctrl && !pstrb[0]
         |=> $stable(st_q.ctrl))
      else $error("masked write changed the register");

   // the status word is read-only
   status_write_err_a: assert property (
      access_phase && pwrite && hit_status |-> pslverr)
      else $error("status write not refused");

   // control accesses never fail
   mapped_ok_a: assert property (
      access_phase && hit_ctrl |-> !pslverr)
      else $error("control access refused");

   // the error flag stands only in an access phase
   idle_no_err_a: assert property (
      !access_phase |-> !pslverr)
      else $error("error flag outside access phase");

   // status read returns routing in bit 8 and the level code below
   status_read_a: assert property (
      setup_phase && !pwrite && hit_status |=>
         prdata == {23'h000000, $past(shared_reference_pin_route), 1'b0,
         $past(ladder_output_level)})
      else $error("status read back wrong");

   // unmapped reads return zero
   unmapped_read_a: assert property (
      setup_phase && !pwrite && !mapped |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");

   // upper read bits are zero, low byte is the register
   read_upper_zero_a: assert property ( // [RULE_10]
      setup_phase && !pwrite && hit_ctrl |=>
         prdata[31:8] == 24'h000000 && prdata[7:0] == $past(st_q.ctrl))
      else $error("control read word wrong");

   // read data does not move past the access phase
   read_hold_a: assert property ( // [RULE_10]
      access_phase |=> $stable(prdata))
      else $error("read data moved after access");

   // highest code is a quarter plus fifteen thirty-seconds; anything above
   // means the tap arithmetic wrapped or the range decode slipped
   level_bound_a: assert property ( // [RULE_05]
      ladder_output_level <= 7'h45)
      else $error("level code out of range");

   // reset puts the level at the high range base
   reset_level_a: assert property ( // [RULE_06]
      disable iff (1'b0) !resetn |=> ladder_output_level == ladder_pkg::HIGH_BASE)
      else $error("level not at base after reset");

   // reset clears range, source, tap and read data as well
   reset_fields_a: assert property ( // [RULE_06]
      disable iff (1'b0) !resetn |=> !ladder_range_select && !ladder_source_select
         && (ladder_tap_index == 4'h0) && (prdata == 32'h00000000))
      else $error("fields not cleared by reset");

   // low range codes step by four ninety-sixths
   low_step_a: assert property ( // [RULE_03]
      $past(ladder_range_select) |-> ladder_output_level[1:0] == 2'b00)
      else $error("low range level off its step");

   // high range never goes below one quarter of the span
   high_base_a: assert property ( // [RULE_03]
      !$past(ladder_range_select) |-> ladder_output_level >= 7'h18)
      else $error("high range level below its base");

endmodule : ladder_reference_control

// file: tb/tb_top.sv
// self-checking bench of the ladder reference control register bank
`timescale 1ns/1ps

module tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic port_f_direction = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic ladder_power_enable, ladder_range_select, ladder_source_select;
   logic ladder_pin_output_enable, shared_reference_pin_route, shared_reference_pin_din_off;
   logic [3:0] ladder_tap_index;
   logic [6:0] ladder_output_level;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   integer seed;
   logic [7:0] m_ctrl;
   logic [31:0] rd;
   logic err;

   ladder_reference_control dut (
      .clk(clk),
      .resetn(resetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .port_f_direction(port_f_direction),
      .ladder_power_enable(ladder_power_enable),
      .ladder_range_select(ladder_range_select),
      .ladder_source_select(ladder_source_select),
      .ladder_tap_index(ladder_tap_index),
      .ladder_output_level(ladder_output_level),
      .ladder_pin_output_enable(ladder_pin_output_enable),
      .shared_reference_pin_route(shared_reference_pin_route),
      .shared_reference_pin_din_off(shared_reference_pin_din_off)
   );

   // 5 ns clock; the timeout stops a hung handshake
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors = errors + 1;
         summarize();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer, entered just after an edge; one idle cycle follows
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // wait for the slave; only the bench timeout ends a hang
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // compares every ladder and pad output and both registers with the model
   task automatic expect_all();
      logic [31:0] lvl;
      logic route;
      lvl = m_ctrl[5] ? m_ctrl[3:0] * 4 : 24 + m_ctrl[3:0] * 3;
      route = m_ctrl[6] & port_f_direction;
      #1;
      check(ladder_power_enable, m_ctrl[7]);
      check(ladder_pin_output_enable, m_ctrl[6]);
      check(shared_reference_pin_route, route);
      check(shared_reference_pin_din_off, route);
      check(ladder_range_select, m_ctrl[5]);
      check(ladder_source_select, m_ctrl[4]);
      check(ladder_tap_index, m_ctrl[3:0]);
      check(ladder_output_level, lvl);
      @(posedge clk);
      apb(12'h000, 1'b0, 32'h0, 4'h0);
      check(rd, {24'h0, m_ctrl});
      apb(12'h004, 1'b0, 32'h0, 4'h0);
      check(rd, {route, 1'b0, lvl[6:0]});
   endtask : expect_all

   task automatic summarize();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   initial begin
      logic [31:0] r;
      seed = 32'hbb27;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      m_ctrl = 8'h00;
      expect_all();
      $display("test reset done");
      // every tap in both ranges, other bits and pin direction random
      for (int i = 0; i < 32; i++) begin
         r = $random(seed);
         m_ctrl = {r[7:6], i[4], r[4], i[3:0]};
         port_f_direction <= r[8];
         apb(12'h000, 1'b1, {r[31:8], m_ctrl}, 4'hf);
         check(err, 1'b0);
         expect_all();
      end
      $display("test sweep done");
      // refused and masked writes must leave the register alone
      apb(12'h000, 1'b1, 32'h0000_00a5, 4'he);
      check(err, 1'b0);
      apb(12'h004, 1'b1, 32'h0000_00a5, 4'hf);
      check(err, 1'b1);
      apb(12'h010, 1'b1, 32'h0000_00a5, 4'hf);
      check(err, 1'b1);
      apb(12'h010, 1'b0, 32'h0, 4'h0);
      check(err, 1'b1);
      check(rd, 32'h00000000);
      expect_all();
      $display("test refusals done");
      // software powers the ladder down before sleep
      m_ctrl[7] = 1'b0;
      apb(12'h000, 1'b1, {24'h000000, m_ctrl}, 4'h1);
      check(err, 1'b0);
      // a long quiet spell stands in for sleep and wake
      repeat (300) @(posedge clk);
      expect_all();
      $display("test hold done");
      // reset in mid-run after all bits were set
      m_ctrl = 8'hff;
      port_f_direction <= 1'b1;
      apb(12'h000, 1'b1, 32'h0000_00ff, 4'h1);
      expect_all();
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      m_ctrl = 8'h00;
      expect_all();
      $display("test second reset done");
      summarize();
   end
endmodule : tb_top
